// File: src/irq_pkg.sv
// constants for the peripheral interrupt enable and flag block
//
// Function
// - 8-bit enable register, bit 4 unused, all bits reset to zero
// - 8-bit flag register matching enable layout, read/write, reset zero
// - bit 4 of both registers ignores writes and reads zero
// - enable one lets its source request; zero blocks it
// - flags set on their event regardless of any enable
// - no peripheral request without the peripheral group enable
// - eeprom write done flag, bit 7, sticky until software clears
// - adc done flag, bit 6, set on conversion complete
// - capture/compare flag, bit 5, capture or compare, unused in pwm
// - comparator change flag, bit 3, sticky until cleared
// - oscillator fail flag, bit 2, sticky until cleared
// - timer2 period match flag, bit 1, sticky until cleared
// - timer1 overflow flag, bit 0, sticky until cleared
package irq_pkg;
    localparam int REG_W = 8;
    localparam int ADDR_W = 4;
    // register offsets
    localparam logic [3:0] OFS_ENABLE = 4'h0;
    localparam logic [3:0] OFS_FLAGS = 4'h1;
    localparam logic [3:0] OFS_CORE = 4'h2;
    localparam logic [3:0] OFS_STATUS = 4'h3;
    localparam logic [3:0] OFS_MASK = 4'h4;
    // bit positions
    localparam int BIT_EEPROM = 7;
    localparam int BIT_ADC = 6;
    localparam int BIT_CAPCMP = 5;
    localparam int BIT_UNUSED = 4;
    localparam int BIT_COMP = 3;
    localparam int BIT_OSC = 2;
    localparam int BIT_TMR2 = 1;
    localparam int BIT_TIMER1_COUNT = 0;
    // core control bit positions
    localparam int BIT_GLOBAL = 7;
    localparam int BIT_GROUP = 6;
    // implemented bits and reset values
    localparam logic [7:0] IMPL_MASK = 8'hef;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [7:0] CORE_MASK = 8'hc0;
    // capture/compare unit modes
    typedef enum logic [1:0]
    {
        CCP_OFF     = 2'b00,
        CCP_CAPTURE = 2'b01,
        CCP_COMPARE = 2'b10,
        CCP_PWM     = 2'b11
    } ccp_mode_t;
endpackage : irq_pkg

// File: src/irq_event_latch.sv
// one bank of sticky bits with set-wins-over-write loading
`timescale 1ns/1ps
module irq_event_latch #(
    parameter int W = 8
) (
    input  wire logic         clk,      // system clock
    input  wire logic         rst,      // sync reset, high
    input  wire logic [W-1:0] set_ev,   // event pulses
    input  wire logic         wr,       // load strobe
    input  wire logic [W-1:0] wr_data,  // value loaded on wr
    input  wire logic [W-1:0] keep,     // implemented bits
    output logic      [W-1:0] q         // latched bits
);
    logic [W-1:0] next_q;

    // =====================================================
    // per-bit next value
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            assign next_q[i] = keep[i] &
                (set_ev[i] | (wr ? wr_data[i] : q[i]));
        end
    endgenerate

    // register bank
    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '0;
        else
            q <= next_q;
    end
endmodule : irq_event_latch

// File: src/peripheral_irq.sv
// peripheral interrupt enable, flag and request logic
`timescale 1ns/1ps
module peripheral_irq (
    input  wire logic             clk,            // system clock
    input  wire logic             rst,            // sync reset, high
    input  wire logic [3:0]       addr,           // register address
    input  wire logic [7:0]       wdata,          // write data
    input  wire logic             wr,             // write strobe
    input  wire logic             rd,             // read strobe
    output logic      [7:0]       rdata,          // read data, next cycle
    input  wire logic             eeprom_done,    // eeprom write finished
    input  wire logic             adc_done,       // conversion finished
    input  wire logic [1:0]       ccp_mode,       // capture/compare mode
    input  wire logic             ccp_capture,    // timer1 capture pulse
    input  wire logic             ccp_match,      // timer1 compare pulse
    input  wire logic             comp_out,       // comparator output
    input  wire logic             osc_fail,       // clock switched to int osc
    input  wire logic             timer2_match,   // timer2 period match
    input  wire logic             timer1_ovf,     // timer1 overflow
    output logic                  core_irq_req,   // request to core
    output logic                  irq             // status level interrupt
);
    // =====================================================
    // registers
    logic [7:0] peripheral_irq_enable;
    logic [7:0] peripheral_irq_flags;
    logic [7:0] core_irq_control;
    logic [7:0] status;
    logic [7:0] mask;
    logic       comp_prev;
    logic       prim_done;

    // =====================================================
    // address decode
    wire sel_en   = (addr == irq_pkg::OFS_ENABLE);
    wire sel_fl   = (addr == irq_pkg::OFS_FLAGS);
    wire sel_core = (addr == irq_pkg::OFS_CORE);
    wire sel_st   = (addr == irq_pkg::OFS_STATUS);
    wire sel_mk   = (addr == irq_pkg::OFS_MASK);
    wire wr_en    = wr & sel_en;
    wire wr_fl    = wr & sel_fl;
    wire wr_core  = wr & sel_core;
    wire wr_st    = wr & sel_st;
    wire wr_mk    = wr & sel_mk;

    // =====================================================
    // source events
    wire ccp_ev = ((ccp_mode == irq_pkg::CCP_CAPTURE) & ccp_capture)
                | ((ccp_mode == irq_pkg::CCP_COMPARE) & ccp_match);
    wire comp_ev = prim_done & (comp_out != comp_prev);
    wire [7:0] events;
    assign events[irq_pkg::BIT_EEPROM] = eeprom_done;
    assign events[irq_pkg::BIT_ADC] = adc_done;
    assign events[irq_pkg::BIT_CAPCMP] = ccp_ev;
    assign events[irq_pkg::BIT_UNUSED] = 1'b0;
    assign events[irq_pkg::BIT_COMP] = comp_ev;
    assign events[irq_pkg::BIT_OSC] = osc_fail;
    assign events[irq_pkg::BIT_TMR2] = timer2_match;
    assign events[irq_pkg::BIT_TIMER1_COUNT] = timer1_ovf;

    // =====================================================
    // flag bank: flags set independent of enables
    irq_event_latch #(
        .W(irq_pkg::REG_W)
    ) u_flags (
        .clk     (clk),
        .rst     (rst),
        .set_ev  (events),
        .wr      (wr_fl),
        .wr_data (wdata),
        .keep    (irq_pkg::IMPL_MASK),
        .q       (peripheral_irq_flags)
    );

    // =====================================================
    // request combination
    wire [7:0] active = peripheral_irq_flags & peripheral_irq_enable;
    wire group_en  = core_irq_control[irq_pkg::BIT_GROUP];
    wire global_en = core_irq_control[irq_pkg::BIT_GLOBAL];
    // and of flag and enable, or-reduced, then group and global gates
    wire next_req  = (|active) & group_en & global_en;
    wire req_rise  = next_req & ~core_irq_req;
    wire [7:0] st_ev = {7'h00, req_rise};
    wire [7:0] next_status =
        st_ev | (status & ~(wr_st ? wdata : irq_pkg::RESET_VAL));

    // =====================================================
    // read mux
    wire [7:0] rmux =
        sel_en   ? peripheral_irq_enable :
        sel_fl   ? peripheral_irq_flags :
        sel_core ? core_irq_control :
        sel_st   ? status :
        sel_mk   ? mask : irq_pkg::RESET_VAL;

    // =====================================================
    // enable and control registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            peripheral_irq_enable <= irq_pkg::RESET_VAL;
            core_irq_control      <= irq_pkg::RESET_VAL;
            mask                  <= irq_pkg::RESET_VAL;
        end
        else
        begin
            if (wr_en)
                peripheral_irq_enable <= wdata & irq_pkg::IMPL_MASK;
            if (wr_core)
                core_irq_control <= wdata & irq_pkg::CORE_MASK;
            if (wr_mk)
                mask <= wdata & 8'h01;
        end
    end

    // status, comparator history and outputs
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            status       <= irq_pkg::RESET_VAL;
            comp_prev    <= 1'b0;
            prim_done    <= 1'b0;
            core_irq_req <= 1'b0;
            irq          <= 1'b0;
            rdata        <= irq_pkg::RESET_VAL;
        end
        else
        begin
            status       <= next_status;
            comp_prev    <= comp_out;
            prim_done    <= 1'b1;
            core_irq_req <= next_req;
            irq          <= |(next_status & mask);
            rdata        <= rd ? rmux : irq_pkg::RESET_VAL;
        end
    end

    // =====================================================
    // assertions, all on the system clock
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_unused_bit_zero: assert property (
        !peripheral_irq_flags[irq_pkg::BIT_UNUSED]
        && !peripheral_irq_enable[irq_pkg::BIT_UNUSED])
        else $error("unused bit set");

    a_enable_write: assert property (
        wr_en |=> peripheral_irq_enable
            == ($past(wdata) & irq_pkg::IMPL_MASK))
        else $error("enable write lost");

    a_enable_hold: assert property (
        !wr_en |=> $stable(peripheral_irq_enable))
        else $error("enable changed unasked");

    a_set_wins: assert property (
        (timer1_ovf && wr_fl && !wdata[irq_pkg::BIT_TIMER1_COUNT])
        |=> peripheral_irq_flags[irq_pkg::BIT_TIMER1_COUNT])
        else $error("event lost on clear");

    a_flag_write: assert property (
        wr_fl |=> peripheral_irq_flags
            == (($past(wdata) | $past(events)) & irq_pkg::IMPL_MASK))
        else $error("flag write wrong");

    // write of zero clears a flag unless its event fires in the same cycle
    a_flag_clear: assert property (
        (wr_fl && !wdata[irq_pkg::BIT_TMR2] && !timer2_match)
        |=> !peripheral_irq_flags[irq_pkg::BIT_TMR2])
        else $error("flag not cleared");

    a_flag_sticky: assert property (
        (peripheral_irq_flags[irq_pkg::BIT_TIMER1_COUNT] && !wr_fl)
        |=> peripheral_irq_flags[irq_pkg::BIT_TIMER1_COUNT])
        else $error("flag dropped");

    a_timer1_sets: assert property (
        timer1_ovf |=> peripheral_irq_flags[irq_pkg::BIT_TIMER1_COUNT])
        else $error("overflow missed");

    a_flag_sets: assert property (
        adc_done |=> peripheral_irq_flags[irq_pkg::BIT_ADC])
        else $error("flag not set");

    a_adc_quiet: assert property (
        (!peripheral_irq_flags[irq_pkg::BIT_ADC] && !adc_done && !wr_fl)
        |=> !peripheral_irq_flags[irq_pkg::BIT_ADC])
        else $error("adc flag set unasked");

    a_eeprom_sets: assert property (
        eeprom_done |=> peripheral_irq_flags[irq_pkg::BIT_EEPROM])
        else $error("eeprom done missed");

    a_eeprom_sticky: assert property (
        (peripheral_irq_flags[irq_pkg::BIT_EEPROM] && !wr_fl)
        |=> peripheral_irq_flags[irq_pkg::BIT_EEPROM])
        else $error("eeprom flag dropped");

    // capture sets flag in capture mode
    a_capture_sets: assert property (
        (ccp_mode == irq_pkg::CCP_CAPTURE && ccp_capture)
        |=> peripheral_irq_flags[irq_pkg::BIT_CAPCMP])
        else $error("capture missed");

    // match sets flag in compare mode
    a_compare_sets: assert property (
        (ccp_mode == irq_pkg::CCP_COMPARE && ccp_match)
        |=> peripheral_irq_flags[irq_pkg::BIT_CAPCMP])
        else $error("compare missed");

    a_pwm_quiet: assert property (
        (ccp_mode == irq_pkg::CCP_PWM && !ccp_ev && !wr_fl
            && !peripheral_irq_flags[irq_pkg::BIT_CAPCMP])
        |=> !peripheral_irq_flags[irq_pkg::BIT_CAPCMP])
        else $error("capcmp set in pwm");

    a_capcmp_sticky: assert property (
        (peripheral_irq_flags[irq_pkg::BIT_CAPCMP] && !wr_fl)
        |=> peripheral_irq_flags[irq_pkg::BIT_CAPCMP])
        else $error("capcmp flag dropped");

    a_comp_change: assert property (
        comp_ev |=> peripheral_irq_flags[irq_pkg::BIT_COMP])
        else $error("comparator change missed");

    a_comp_sticky: assert property (
        (peripheral_irq_flags[irq_pkg::BIT_COMP] && !wr_fl)
        |=> peripheral_irq_flags[irq_pkg::BIT_COMP])
        else $error("comparator flag dropped");

    a_osc_sets: assert property (
        osc_fail |=> peripheral_irq_flags[irq_pkg::BIT_OSC])
        else $error("oscillator fail missed");

    a_osc_sticky: assert property (
        (peripheral_irq_flags[irq_pkg::BIT_OSC] && !wr_fl)
        |=> peripheral_irq_flags[irq_pkg::BIT_OSC])
        else $error("oscillator flag dropped");

    a_timer2_sets: assert property (
        timer2_match |=> peripheral_irq_flags[irq_pkg::BIT_TMR2])
        else $error("timer2 match missed");

    a_timer2_sticky: assert property (
        (peripheral_irq_flags[irq_pkg::BIT_TMR2] && !wr_fl)
        |=> peripheral_irq_flags[irq_pkg::BIT_TMR2])
        else $error("timer2 flag dropped");

    a_group_gate: assert property (
        !$past(group_en) |-> !core_irq_req)
        else $error("request without group enable");

    a_global_gate: assert property (
        !$past(global_en) |-> !core_irq_req)
        else $error("request without global enable");

    a_req_value: assert property (
        ##1 core_irq_req == $past(next_req))
        else $error("request mismatch");

    a_enable_blocks: assert property (
        !$past(|active) |-> !core_irq_req)
        else $error("request from blocked source");

    a_req_needs_flag: assert property (
        core_irq_req |-> $past(|peripheral_irq_flags))
        else $error("request without flag");

    a_read_enable: assert property (
        (rd && sel_en) |=> rdata == $past(peripheral_irq_enable))
        else $error("enable read wrong");

    a_read_flags: assert property (
        (rd && sel_fl) |=> rdata == $past(peripheral_irq_flags))
        else $error("flag read wrong");

    // bit 4 of every read is zero
    a_read_unused: assert property (
        rd |=> !rdata[irq_pkg::BIT_UNUSED])
        else $error("unused bit read as one");

    // main scenarios
    c_request: cover property ($rose(core_irq_req));
    c_clear_race: cover property (timer1_ovf && wr_fl);
    c_irq: cover property ($rose(irq));
    c_comp_change: cover property (comp_ev);
    c_capcmp_event: cover property (ccp_ev);
endmodule : peripheral_irq

// File: verification/periph_model.sv
// peripheral event source model driving the flag inputs
`timescale 1ns/1ps
module periph_model (
    input  wire logic       clk,          // system clock
    input  wire logic [7:0] fire,         // one-cycle event requests
    output logic            eeprom_done,  // eeprom write finished
    output logic            adc_done,     // conversion finished
    output logic            ccp_capture,  // capture pulse
    output logic            ccp_match,    // compare pulse
    output logic            comp_out,     // comparator level
    output logic            osc_fail,     // clock failed over
    output logic            timer2_match, // period match
    output logic            timer1_ovf    // counter overflow
);
    logic comp_q = 1'b0;
    // each event except the comparator is a single high cycle of its fire bit
    assign eeprom_done  = fire[7];
    assign adc_done     = fire[6];
    assign ccp_capture  = fire[5];
    assign ccp_match    = fire[5];
    assign osc_fail     = fire[2];
    assign timer2_match = fire[1];
    assign timer1_ovf   = fire[0];
    assign comp_out     = comp_q;
    // comparator output flips level on request
    always @(posedge clk)
    begin
        if (fire[3])
            comp_q <= ~comp_q;
    end
endmodule : periph_model

// File: verification/tb_peripheral_irq.sv
// self-checking bench for the peripheral interrupt block
`timescale 1ns/1ps
module tb_peripheral_irq;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] fire = 8'h00;
    logic [1:0] ccp_mode = 2'b01;
    logic [7:0] rdata;
    logic       core_irq_req, irq, ee, ad, cap, mat, cm, os, t2, t1;
    int         error_cnt = 0;
    int         checks = 0;
    logic [7:0] v;

    periph_model model_u (.clk(clk), .fire(fire), .eeprom_done(ee),
        .adc_done(ad), .ccp_capture(cap), .ccp_match(mat), .comp_out(cm),
        .osc_fail(os), .timer2_match(t2), .timer1_ovf(t1));
    peripheral_irq dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .eeprom_done(ee), .adc_done(ad),
        .ccp_mode(ccp_mode), .ccp_capture(cap), .ccp_match(mat),
        .comp_out(cm), .osc_fail(os), .timer2_match(t2), .timer1_ovf(t1),
        .core_irq_req(core_irq_req), .irq(irq));

    // ==========================================
    // clock and helpers
    initial
    begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic pulse(input logic [7:0] m);
        @(posedge clk);
        fire <= m;
        @(posedge clk);
        fire <= 8'h00;
    endtask : pulse
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask : settle

    // ==========================================
    // scenarios
    task automatic t_reset();
        rd_reg(irq_pkg::OFS_ENABLE, v);
        chk(v, 8'h00);
        rd_reg(irq_pkg::OFS_FLAGS, v);
        chk(v, 8'h00);
        rd_reg(4'hf, v);
        chk(v, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_bits();
        wr_reg(irq_pkg::OFS_ENABLE, 8'hff);
        rd_reg(irq_pkg::OFS_ENABLE, v);
        chk(v, 8'hef);
        wr_reg(irq_pkg::OFS_FLAGS, 8'hff);
        rd_reg(irq_pkg::OFS_FLAGS, v);
        chk(v, 8'hef);
        wr_reg(irq_pkg::OFS_FLAGS, 8'h00);
        rd_reg(irq_pkg::OFS_FLAGS, v);
        chk(v, 8'h00);
        wr_reg(irq_pkg::OFS_ENABLE, 8'h00);
        $display("test bits done");
    endtask : t_bits
    task automatic t_events();
        for (int b = 0; b < 8; b++)
        begin
            if (b != irq_pkg::BIT_UNUSED)
            begin
                pulse(8'h01 << b);
                rd_reg(irq_pkg::OFS_FLAGS, v);
                chk(v, 8'h01 << b);
                wr_reg(irq_pkg::OFS_FLAGS, 8'h00);
            end
        end
        ccp_mode <= 2'b11;
        pulse(8'h20);
        rd_reg(irq_pkg::OFS_FLAGS, v);
        chk(v, 8'h00);
        ccp_mode <= 2'b10;
        pulse(8'h20);
        rd_reg(irq_pkg::OFS_FLAGS, v);
        chk(v, 8'h20);
        wr_reg(irq_pkg::OFS_FLAGS, 8'h00);
        ccp_mode <= 2'b01;
        $display("test events done");
    endtask : t_events
    task automatic t_request();
        wr_reg(irq_pkg::OFS_FLAGS, 8'h00);
        wr_reg(irq_pkg::OFS_MASK, 8'h01);
        pulse(8'h01);
        wr_reg(irq_pkg::OFS_ENABLE, 8'h01);
        wr_reg(irq_pkg::OFS_CORE, 8'h40);
        settle();
        chk({7'h00, core_irq_req}, 8'h00);
        wr_reg(irq_pkg::OFS_CORE, 8'h80);
        settle();
        chk({7'h00, core_irq_req}, 8'h00);
        wr_reg(irq_pkg::OFS_CORE, 8'hc0);
        settle();
        chk({7'h00, core_irq_req}, 8'h01);
        chk({7'h00, irq}, 8'h01);
        rd_reg(irq_pkg::OFS_STATUS, v);
        chk(v, 8'h01);
        wr_reg(irq_pkg::OFS_ENABLE, 8'h00);
        settle();
        chk({7'h00, core_irq_req}, 8'h00);
        wr_reg(irq_pkg::OFS_MASK, 8'h00);
        settle();
        chk({7'h00, irq}, 8'h00);
        wr_reg(irq_pkg::OFS_MASK, 8'h01);
        settle();
        chk({7'h00, irq}, 8'h01);
        wr_reg(irq_pkg::OFS_STATUS, 8'h01);
        settle();
        chk({7'h00, irq}, 8'h00);
        $display("test request done");
    endtask : t_request
    task automatic t_clash();
        fork
            pulse(8'h02);
            wr_reg(irq_pkg::OFS_FLAGS, 8'h00);
        join
        rd_reg(irq_pkg::OFS_FLAGS, v);
        chk(v, 8'h02);
        wr_reg(irq_pkg::OFS_FLAGS, 8'h00);
        $display("test clash done");
    endtask : t_clash
    task automatic conclude();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    // ==========================================
    // main sequence and watchdog
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_bits();
        t_events();
        t_request();
        t_clash();
        conclude();
    end
    initial
    begin
        #20000;
        error_cnt++;
        conclude();
    end
endmodule : tb_peripheral_irq
